// [rtl/mwl_link_map.vh]
`ifndef MWL_LINK_MAP_VH
`define MWL_LINK_MAP_VH
// ==========================================================
// Register offsets (byte addresses)
`define MWL_A_CTRL 8'h00
`define MWL_A_SRCST 8'h04
`define MWL_A_SRCLEN 8'h08
`define MWL_A_STSET 8'h10
`define MWL_A_CNTSET 8'h14
`define MWL_A_RETRY 8'h18
`define MWL_A_TMO 8'h1C
`define MWL_A_OWN 8'h20
`define MWL_A_ACT 8'h24
`define MWL_A_SCAN 8'h28
`define MWL_A_PEAK 8'h2C
`define MWL_A_FLAGS 8'h30
`define MWL_R_CNT 2'b01
`define MWL_R_CODE 2'b10
// ==========================================================
// Control and flag fields
`define MWL_B_EN 0
`define MWL_B_PORT 1
`define MWL_B_ACT 16
`define MWL_B_CARD 17
`define MWL_B_BUILT 18
// ==========================================================
// Limits and defaults
`define MWL_SRC_MAX 13'h1F3F
`define MWL_LEN_MAX 6'h28
`define MWL_DEF_ADDR 4'h0
`define MWL_DEF_CNT 4'h7
`define MWL_DEF_RETRY 4'h3
`define MWL_MAX_RETRY 4'hA
`define MWL_DEF_TMO 8'h05
`define MWL_MIN_TMO 8'h05
// ==========================================================
// Error codes
`define MWL_E_TMO 8'h01
`define MWL_E_NUM 8'h02
`define MWL_E_SEQ 8'h03
`define MWL_E_FRM 8'h04
`define MWL_E_NOREQ 8'h11
`define MWL_E_MFRM 8'h14
`define MWL_E_NOSLV 8'h21
`define MWL_E_ADDR 8'h22
`define MWL_E_OSEQ 8'h23
`define MWL_E_EARLY 8'h31
`define MWL_E_INSTR 8'h32
// ==========================================================
// Timing: tick of 10 ms at a 50 MHz clock
`define MWL_TICK_MS 10
`define MWL_CLK_KHZ 50000
`endif

// [rtl/mwl_link.v]
// Register access over APB and the register addresses were left to the implementer.
`timescale 1ns/100ps
`include "mwl_link_map.vh"
// Notes on behaviour
// R1 - Source block: start word 0 to 7999, length 1 to 40 words.
// R2 - Port operand: 0 built-in RS-485 port, 1 expansion card.
// R3 - One master polls at most 15 slave stations.
// R4 - Only the first enabled port runs; never both at once.
// R5 - Frame format and rate come from a per-port config word; the block has no such word, only the mode flags.
// R6 - Read-only error flag for master and each slave 1 to 15.
// R7 - Link-active flag high while the link instruction is enabled; stays low when the source block is bad (S_BAD).
// R8 - Two mode flags show card or built-in port carries the link.
// R9 - Station address 0 master, 1 to 15 slave; copy in use readable.
// R10 - Slave count 1 to 15, default 7, bounds master polling.
// R11 - Retries 0 to 10, default 3; beyond that, slave error.
// R12 - Response time-out 5 to 255 times 10 ms, default 5.
// R13 - Current and peak scan time reported in 10 ms units.
// R14 - Settings take effect at program start or power-on only.
// R15 - Error counter and latest code per master and slave.
// R16 - Master records 01H, 02H, 03H, 04H for slave faults.
// R17 - Slave records 11H for missing next request, 14H bad frame.
// R18 - Other slaves record 21H, 22H, 23H for a slave's faults.
// R19 - Request before parameters accepted gives 31H; 32H bad instruction.
// R20 - Master polls slaves 1 to count in order, repeating.
module mwl_link #(
  parameter TICK_CYC = `MWL_TICK_MS * `MWL_CLK_KHZ
) (
  input wire core_clk,
  input wire rst_n,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire rxValid,
  input wire rxFromMaster,
  input wire [3:0] rxStation,
  input wire [7:0] rxSeq,
  input wire rxBad,
  output reg txReq,
  output reg [3:0] txDst,
  output reg [7:0] txSeq,
  output reg [12:0] txStart,
  output reg [5:0] txLen,
  output reg linkActive,
  output reg cardMode,
  output reg builtinMode
);
  localparam S_IDLE = 5'b00001;
  localparam S_SEND = 5'b00010;
  localparam S_WAIT = 5'b00100;
  localparam S_SLV = 5'b01000;
  localparam S_BAD = 5'b10000;

  reg ctrlEn_q, ctrlPort_q;
  reg [12:0] srcStart_q;
  reg [5:0] srcLen_q;
  reg [3:0] setAddr_q, setCnt_q, setRetry_q;
  reg [7:0] setTmo_q;
  reg [3:0] ownAddr_q, actCnt_q, appRetry_q;
  reg [7:0] appTmo_q;
  reg [4:0] state_q;
  reg [3:0] dst_q, tries_q, lastDst_q;
  reg [7:0] seq_q, lastSeq_q, failCode_q, tmoCnt_q;
  reg waitNext_q;
  reg [19:0] tickCnt_q;
  reg [15:0] scanCnt_q, scanNow_q, scanPeak_q;
  reg [31:0] rdData;
  reg rdErr;
  reg errEv, okEv, scanEv;
  reg [3:0] errIdx, okIdx;
  reg [7:0] errVal;
  wire [15:0] errFlags;
  wire [15:0] cntW [0:15];
  wire [7:0] codeW [0:15];
  wire apbAcc = psel & penable & ~pready;
  wire apbWr = psel & penable & pready & pwrite;
  wire tick = (tickCnt_q == TICK_CYC - 1);
  wire tmoHit = (tmoCnt_q >= appTmo_q);
  wire srcOk = (srcStart_q <= `MWL_SRC_MAX) && (srcLen_q != 6'h00) &&
    (srcLen_q <= `MWL_LEN_MAX);
  wire startReq = ctrlEn_q & (state_q == S_IDLE);
  wire slvRx = rxValid & ~rxFromMaster;
  wire mstRx = rxValid & rxFromMaster;

  // ========================================================
  // APB slave: one wait state, then answer
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= apbAcc;
      if (apbAcc) begin
        prdata <= pwrite ? 32'h0000_0000 : rdData;
        pslverr <= rdErr;
      end
    end
  end

  // Register writes, taken at the completing edge
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrlEn_q <= 1'b0;
      ctrlPort_q <= 1'b0;
      srcStart_q <= 13'h0000;
      srcLen_q <= 6'h01;
      setAddr_q <= `MWL_DEF_ADDR;
      setCnt_q <= `MWL_DEF_CNT;
      setRetry_q <= `MWL_DEF_RETRY;
      setTmo_q <= `MWL_DEF_TMO;
    end else if (apbWr) begin
      case (paddr)
        `MWL_A_CTRL: begin
          ctrlEn_q <= pwdata[`MWL_B_EN];
          ctrlPort_q <= pwdata[`MWL_B_PORT]; // R2
        end
        `MWL_A_SRCST: srcStart_q <= pwdata[12:0];
        `MWL_A_SRCLEN: srcLen_q <= pwdata[5:0];
        `MWL_A_STSET: setAddr_q <= pwdata[3:0];
        `MWL_A_CNTSET: setCnt_q <= pwdata[3:0];
        `MWL_A_RETRY: setRetry_q <= pwdata[3:0];
        `MWL_A_TMO: setTmo_q <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  // Read decode; unmapped addresses answer with an error
  always @* begin
    rdData = 32'h0000_0000;
    rdErr = 1'b0;
    case (paddr[7:6])
      `MWL_R_CNT: rdData = {16'h0000, cntW[paddr[5:2]]}; // R15
      `MWL_R_CODE: rdData = {24'h00_0000, codeW[paddr[5:2]]}; // R15
      default: begin
        case (paddr)
          `MWL_A_CTRL: rdData = {30'h0000_0000, ctrlPort_q, ctrlEn_q};
          `MWL_A_SRCST: rdData = {19'h0_0000, srcStart_q};
          `MWL_A_SRCLEN: rdData = {26'h000_0000, srcLen_q};
          `MWL_A_STSET: rdData = 32'h0000_0000;
          `MWL_A_CNTSET: rdData = 32'h0000_0000;
          `MWL_A_RETRY: rdData = {28'h000_0000, setRetry_q};
          `MWL_A_TMO: rdData = {24'h00_0000, setTmo_q};
          `MWL_A_OWN: rdData = {28'h000_0000, ownAddr_q}; // R9
          `MWL_A_ACT: rdData = {28'h000_0000, actCnt_q}; // R10
          `MWL_A_SCAN: rdData = {16'h0000, scanNow_q}; // R13
          `MWL_A_PEAK: rdData = {16'h0000, scanPeak_q}; // R13
          `MWL_A_FLAGS: rdData = {13'h0000, builtinMode, cardMode,
            linkActive, errFlags}; // R6
          default: rdErr = 1'b1;
        endcase
      end
    endcase
  end

  // ========================================================
  // 10 ms tick and scan timer
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tickCnt_q <= 20'h0_0000;
      scanCnt_q <= 16'h0000;
      scanNow_q <= 16'h0000;
      scanPeak_q <= 16'h0000;
    end else begin
      if (!linkActive || tick)
        tickCnt_q <= 20'h0_0000;
      else
        tickCnt_q <= tickCnt_q + 20'h0_0001;
      if (!linkActive) begin
        scanCnt_q <= 16'h0000;
      end else if (scanEv) begin
        scanNow_q <= scanCnt_q; // R13
        if (scanCnt_q > scanPeak_q)
          scanPeak_q <= scanCnt_q; // R13
        scanCnt_q <= 16'h0000;
      end else if (tick) begin
        scanCnt_q <= scanCnt_q + 16'h0001;
      end
    end
  end

  // ========================================================
  // Error and success events for the station table
  always @* begin
    errEv = 1'b0;
    errIdx = 4'h0;
    errVal = 8'h00;
    okEv = 1'b0;
    okIdx = 4'h0;
    scanEv = 1'b0;
    if (startReq && !srcOk) begin
      errEv = 1'b1; // R19
      errIdx = setAddr_q;
      errVal = `MWL_E_INSTR;
    end else if (!linkActive && ctrlEn_q && mstRx &&
        rxStation == setAddr_q && rxStation != 4'h0) begin
      errEv = 1'b1; // R19
      errIdx = setAddr_q;
      errVal = `MWL_E_EARLY;
    end else if (state_q == S_WAIT) begin
      if (slvRx && (rxBad || rxStation != dst_q || rxSeq != seq_q)) begin
        if (tries_q >= appRetry_q) begin
          errEv = 1'b1; // R11
          errIdx = dst_q;
          errVal = rxBad ? `MWL_E_FRM :
            (rxStation != dst_q) ? `MWL_E_NUM : `MWL_E_SEQ; // R16
        end
      end else if (slvRx) begin
        okEv = 1'b1; // R6
        okIdx = dst_q;
        scanEv = (dst_q >= actCnt_q);
      end else if (tick && tmoHit && tries_q >= appRetry_q) begin
        errEv = 1'b1; // R11
        errIdx = dst_q;
        errVal = `MWL_E_TMO; // R16
      end
      if (errEv)
        scanEv = (dst_q >= actCnt_q);
    end else if (state_q == S_SLV) begin
      if (mstRx && rxBad) begin
        errEv = 1'b1;
        errVal = `MWL_E_MFRM; // R17
      end else if (mstRx) begin
        okEv = 1'b1;
        scanEv = (rxStation == 4'h1);
      end else if (slvRx && rxBad) begin
        errEv = 1'b1;
        errIdx = rxStation;
        errVal = `MWL_E_FRM;
      end else if (slvRx && rxStation == ownAddr_q) begin
        errEv = 1'b1; // R18
        errIdx = rxStation;
        errVal = `MWL_E_NOSLV;
      end else if (slvRx && rxStation != lastDst_q) begin
        errEv = 1'b1; // R18
        errIdx = rxStation;
        errVal = `MWL_E_ADDR;
      end else if (slvRx && rxSeq != lastSeq_q) begin
        errEv = 1'b1; // R18
        errIdx = rxStation;
        errVal = `MWL_E_OSEQ;
      end else if (slvRx) begin
        okEv = 1'b1;
        okIdx = rxStation;
      end else if (waitNext_q && tick && tmoHit) begin
        errEv = 1'b1;
        errVal = `MWL_E_NOREQ; // R17
      end
    end
  end

  // ========================================================
  // Per-station flag, error counter and latest error code
  genvar g;
  generate
    for (g = 0; g < 16; g = g + 1) begin : gEnt
      reg flag_q;
      reg [15:0] cnt_q;
      reg [7:0] code_q;
      always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          flag_q <= 1'b0;
          cnt_q <= 16'h0000;
          code_q <= 8'h00;
        end else if (errEv && errIdx == g) begin
          flag_q <= 1'b1; // R6
          cnt_q <= cnt_q + 16'h0001; // R15
          code_q <= errVal; // R15
        end else if (okEv && okIdx == g) begin
          flag_q <= 1'b0; // R6
        end
      end
      assign errFlags[g] = flag_q;
      assign cntW[g] = cnt_q;
      assign codeW[g] = code_q;
    end
  endgenerate

  // ========================================================
  // Link sequencer: start, master polling, slave answering
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= S_IDLE;
      ownAddr_q <= `MWL_DEF_ADDR;
      actCnt_q <= `MWL_DEF_CNT;
      appRetry_q <= `MWL_DEF_RETRY;
      appTmo_q <= `MWL_DEF_TMO;
      linkActive <= 1'b0;
      cardMode <= 1'b0;
      builtinMode <= 1'b0;
      dst_q <= 4'h1;
      tries_q <= 4'h0;
      seq_q <= 8'h00;
      lastDst_q <= 4'h0;
      lastSeq_q <= 8'h00;
      tmoCnt_q <= 8'h00;
      waitNext_q <= 1'b0;
      txReq <= 1'b0;
      txDst <= 4'h0;
      txSeq <= 8'h00;
      txStart <= 13'h0000;
      txLen <= 6'h00;
    end else begin
      txReq <= 1'b0;
      if (tick)
        tmoCnt_q <= tmoCnt_q + 8'h01; // R12
      if (!ctrlEn_q) begin
        state_q <= S_IDLE; // R7
        linkActive <= 1'b0;
        cardMode <= 1'b0;
        builtinMode <= 1'b0;
        waitNext_q <= 1'b0;
      end else begin
        case (state_q)
          S_IDLE: begin
            if (!srcOk) begin
              state_q <= S_BAD; // R1
            end else begin
              // Settings are latched only here, at start
              ownAddr_q <= setAddr_q; // R14
              actCnt_q <= (setCnt_q == 4'h0) ? 4'h1 : setCnt_q; // R10
              appRetry_q <= (setRetry_q > `MWL_MAX_RETRY) ?
                `MWL_MAX_RETRY : setRetry_q; // R11
              appTmo_q <= (setTmo_q < `MWL_MIN_TMO) ?
                `MWL_MIN_TMO : setTmo_q; // R12
              txStart <= srcStart_q; // R1
              txLen <= srcLen_q; // R1
              linkActive <= 1'b1; // R7
              // Port fixed at start; sets cardMode or builtinMode
              cardMode <= ctrlPort_q; // R4 R5 R8
              builtinMode <= ~ctrlPort_q; // R4 R8
              dst_q <= 4'h1; // R20
              tries_q <= 4'h0;
              tmoCnt_q <= 8'h00;
              state_q <= (setAddr_q == 4'h0) ? S_SEND : S_SLV; // R9
            end
          end
          S_SEND: begin
            txReq <= 1'b1;
            txDst <= dst_q; // R3
            txSeq <= seq_q;
            tmoCnt_q <= 8'h00;
            state_q <= S_WAIT;
          end
          S_WAIT: begin
            if (okEv || errEv) begin
              if (okEv)
                seq_q <= seq_q + 8'h01;
              tries_q <= 4'h0;
              if (dst_q >= actCnt_q)
                dst_q <= 4'h1; // R20
              else
                dst_q <= dst_q + 4'h1; // R20
              state_q <= S_SEND;
            end else if (slvRx || (tick && tmoHit)) begin
              tries_q <= tries_q + 4'h1; // R11
              state_q <= S_SEND;
            end
          end
          S_SLV: begin
            if (mstRx && !rxBad) begin
              lastDst_q <= rxStation;
              lastSeq_q <= rxSeq;
              waitNext_q <= 1'b0;
              if (rxStation == ownAddr_q) begin
                txReq <= 1'b1;
                txDst <= 4'h0;
                txSeq <= rxSeq;
                tmoCnt_q <= 8'h00;
                waitNext_q <= 1'b1; // R17
              end
            end else if (errEv && errVal == `MWL_E_NOREQ) begin
              waitNext_q <= 1'b0;
            end
          end
          S_BAD: state_q <= S_BAD; // R19
          default: state_q <= S_IDLE;
        endcase
      end
    end
  end
endmodule // mwl_link

// [verification/mwl_link_props.sv]
`timescale 1ns/100ps
// ==========================================
// Checker on the link block ports
module mwl_link_props (
  input wire core_clk,
  input wire rst_n,
  input wire psel,
  input wire penable,
  input wire pready,
  input wire pslverr,
  input wire txReq,
  input wire [3:0] txDst,
  input wire [7:0] txSeq,
  input wire [12:0] txStart,
  input wire [5:0] txLen,
  input wire linkActive,
  input wire cardMode,
  input wire builtinMode
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  // First access cycle of a transfer
  sequence sAccess;
    psel && penable && !pready;
  endsequence
  // A poll sent by the master
  sequence sPoll;
    txReq && txDst != 4'h0;
  endsequence
  // Bus answers and link outputs
  AST_READY_DELAY: assert property (sAccess |=> pready)
    else $error("pready not one cycle after access");
  AST_READY_PULSE: assert property (pready |=> !pready)
    else $error("pready high for more than a cycle");
  AST_ERR_WITH_READY: assert property ($rose(pslverr) |-> pready)
    else $error("pslverr raised without pready");
  AST_REQ_PULSE: assert property (txReq |=> !txReq)
    else $error("txReq longer than one cycle");
  AST_REQ_ACTIVE: assert property (txReq |-> linkActive)
    else $error("frame requested while link idle");
  AST_ONE_PORT: assert property (!(cardMode && builtinMode))
    else $error("both ports run the link");
  AST_MODE_FLAG: assert property ((cardMode || builtinMode) == linkActive)
    else $error("mode flags disagree with link state");
  AST_SRC_RANGE: assert property (sPoll |-> txLen != 6'h00 &&
    txLen <= 6'h28 && txStart <= 13'h1F3F)
    else $error("source block out of range");
  AST_TX_HOLD: assert property (!txReq && linkActive && $past(linkActive)
    |-> $stable(txDst) && $stable(txSeq))
    else $error("frame fields changed between requests");
endmodule // mwl_link_props

// [verification/mwl_slave_model.sv]
`timescale 1ns/100ps
// ==========================================
// Far-side slave stations
module mwl_slave_model (
  input wire core_clk,
  input wire rst_n,
  input wire txReq,
  input wire [3:0] txDst,
  input wire [7:0] txSeq,
  input wire [2:0] fault,
  input wire slow,
  input wire asMaster,
  output reg rxValid,
  output reg rxFromMaster,
  output reg [3:0] rxStation,
  output reg [7:0] rxSeq,
  output reg rxBad
);
  reg [3:0] waitQ;
  reg [4:0] gapQ;
  reg [7:0] mSeq;
  // Answer master polls after a delay, or poll as the master station
  // only once the bench has the block running as a slave
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      waitQ <= 4'h0;
      gapQ <= 5'h00;
      mSeq <= 8'h00;
      rxValid <= 1'b0;
      rxFromMaster <= 1'b0;
      rxStation <= 4'h0;
      rxSeq <= 8'h00;
      rxBad <= 1'b0;
    end else begin
      rxValid <= 1'b0;
      rxFromMaster <= 1'b0;
      rxBad <= 1'b0;
      rxStation <= ~rxStation; // Released lines keep moving
      rxSeq <= ~rxSeq;
      if (asMaster) begin
        gapQ <= gapQ + 5'h01;
        if (gapQ == 5'h1F) begin
          rxValid <= 1'b1; // Master with a slave count of one
          rxFromMaster <= 1'b1;
          rxStation <= 4'h1;
          rxSeq <= mSeq;
          mSeq <= mSeq + 8'h01;
        end
      end else if (txReq && txDst != 4'h0 && fault != 3'h1) begin
        waitQ <= slow ? 4'hC : 4'h2;
      end else if (waitQ == 4'h1) begin
        waitQ <= 4'h0;
        rxValid <= 1'b1;
        rxStation <= (fault == 3'h2) ? txDst + 4'h1 : txDst;
        rxSeq <= (fault == 3'h3) ? txSeq + 8'h01 : txSeq;
        rxBad <= (fault == 3'h4);
      end else if (waitQ != 4'h0) begin
        waitQ <= waitQ - 4'h1;
      end
    end
  end
endmodule // mwl_slave_model

// [verification/mwl_link_tb_top.sv]
`timescale 1ns/100ps
`include "mwl_link_map.vh"
// ==========================================
// Bench for the word link block
module mwl_link_tb_top;
  reg core_clk = 1'b0;
  reg rst_n = 1'b0;
  reg psel = 1'b0;
  reg penable = 1'b0;
  reg pwrite = 1'b0;
  reg [7:0] paddr = 8'h00;
  reg [31:0] pwdata = 32'h0000_0000;
  reg [2:0] fault = 3'h0;
  reg slow = 1'b0;
  reg asMaster = 1'b0;
  reg [11:0] lastTx = 12'h000;
  reg perr;
  reg [31:0] r;
  reg [3:0] polls [0:7];
  wire [31:0] prdata;
  wire pready, pslverr, rxValid, rxFromMaster, rxBad, txReq;
  wire linkActive, cardMode, builtinMode;
  wire [3:0] rxStation, txDst;
  wire [7:0] rxSeq, txSeq;
  wire [12:0] txStart;
  wire [5:0] txLen;
  integer nPoll = 0;
  integer miscompares = 0;
  integer nChecks = 0;
  integer cyc = 0;
  integer i;
  // Design with a short tick
  mwl_link #(.TICK_CYC(20)) mwl_link_inst (
    .core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rxValid(rxValid),
    .rxFromMaster(rxFromMaster), .rxStation(rxStation), .rxSeq(rxSeq),
    .rxBad(rxBad), .txReq(txReq), .txDst(txDst), .txSeq(txSeq),
    .txStart(txStart), .txLen(txLen), .linkActive(linkActive),
    .cardMode(cardMode), .builtinMode(builtinMode));
  // Other stations on the line
  mwl_slave_model mwl_slave_model_inst (
    .core_clk(core_clk), .rst_n(rst_n), .txReq(txReq), .txDst(txDst),
    .txSeq(txSeq), .fault(fault), .slow(slow), .asMaster(asMaster),
    .rxValid(rxValid), .rxFromMaster(rxFromMaster),
    .rxStation(rxStation), .rxSeq(rxSeq), .rxBad(rxBad));
  // Clock
  initial begin
    forever #10 core_clk = ~core_clk;
  end
  // Cycle limit and poll recorder
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (txReq === 1'b1)
      lastTx <= {txDst, txSeq};
    if (txReq === 1'b1 && nPoll < 8) begin
      polls[nPoll] <= txDst;
      nPoll <= nPoll + 1;
    end
    if (cyc == 60000) begin
      miscompares = miscompares + 1;
      conclude;
    end
  end
  task conclude;
    begin
      $display("checks %0d miscompares %0d", nChecks, miscompares);
      if (miscompares == 0 && nChecks > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask
  task chk(input [7:0] a, input [31:0] e, input [31:0] g);
    begin
      nChecks = nChecks + 1;
      if (g !== e) begin
        miscompares = miscompares + 1;
        $display("Error item %h expected %h seen %h", a, e, g);
      end
    end
  endtask
  task apb(input w, input [7:0] a, input [31:0] d);
    begin
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      @(posedge core_clk);
      // Wait for the answer; only the cycle limit ends a hang
      while (pready !== 1'b1)
        @(posedge core_clk);
      r = prdata;
      perr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge core_clk);
    end
  endtask
  task rd(input [7:0] a, input [31:0] e);
    begin
      apb(1'b0, a, 32'h0000_0000);
      chk(a, e, r);
    end
  endtask
  task wr(input [7:0] a, input [31:0] d);
    apb(1'b1, a, d);
  endtask
  // Poll the flag word until the masked bits match
  task waitFlag(input [31:0] m, input [31:0] v);
    integer k;
    begin
      k = 0;
      apb(1'b0, `MWL_A_FLAGS, 32'h0000_0000);
      while ((r & m) !== v && k < 300) begin
        apb(1'b0, `MWL_A_FLAGS, 32'h0000_0000);
        k = k + 1;
      end
      chk(`MWL_A_FLAGS, v, r & m);
    end
  endtask
  // Main sequence
  initial begin
    repeat (20) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    rd(`MWL_A_RETRY, 32'h0000_0003);
    rd(`MWL_A_TMO, 32'h0000_0005);
    rd(`MWL_A_CNTSET, 32'h0000_0000);
    rd(8'h3C, 32'h0000_0000);
    chk(8'h3C, 32'h0000_0001, {31'h0000_0000, perr});
    wr(`MWL_A_RETRY, 32'h0000_0001);
    wr(`MWL_A_CNTSET, 32'h0000_0002);
    wr(`MWL_A_SRCST, 32'h0000_1F3F);
    wr(`MWL_A_SRCLEN, 32'h0000_0028);
    wr(`MWL_A_CTRL, 32'h0000_0003);
    rd(`MWL_A_FLAGS, 32'h0003_0000);
    rd(`MWL_A_ACT, 32'h0000_0002);
    rd(`MWL_A_OWN, 32'h0000_0000);
    chk(8'hF0, 32'h0000_1F3F, {19'h0_0000, txStart});
    chk(8'hF1, 32'h0000_0028, {26'h000_0000, txLen});
    i = 0;
    while (nPoll < 4 && i < 500) begin
      @(posedge core_clk);
      i = i + 1;
    end
    for (i = 0; i < 4; i = i + 1)
      chk(8'hE0, i % 2 + 1, {28'h000_0000, polls[i]});
    // Each slave fault kind in turn, then a clean exchange
    for (i = 1; i < 5; i = i + 1) begin
      fault <= i[2:0];
      waitFlag(32'h0000_0002, 32'h0000_0002);
      rd(8'h84, i);
      fault <= 3'h0;
      waitFlag(32'h0000_0002, 32'h0000_0000);
    end
    apb(1'b0, 8'h44, 32'h0000_0000);
    chk(8'h44, 32'h0000_0001, {31'h0000_0000, r[15:0] >= 16'h0004});
    // A scan with timed-out slaves lasts at least one time-out
    apb(1'b0, `MWL_A_PEAK, 32'h0000_0000);
    chk(`MWL_A_PEAK, 32'h0000_0001, {31'h0000_0000, r[15:0] >= 16'h0005});
    wr(`MWL_A_CNTSET, 32'h0000_0000);
    rd(`MWL_A_ACT, 32'h0000_0002);
    // Port change while running is ignored
    wr(`MWL_A_CTRL, 32'h0000_0001);
    waitFlag(32'h0007_0000, 32'h0003_0000);
    wr(`MWL_A_CTRL, 32'h0000_0000);
    waitFlag(32'h0007_0000, 32'h0000_0000);
    slow <= 1'b1;
    wr(`MWL_A_CTRL, 32'h0000_0001);
    rd(`MWL_A_ACT, 32'h0000_0001);
    waitFlag(32'h0007_0000, 32'h0005_0000);
    wr(`MWL_A_CTRL, 32'h0000_0000);
    wr(`MWL_A_SRCLEN, 32'h0000_0000);
    wr(`MWL_A_CTRL, 32'h0000_0001);
    waitFlag(32'h0001_0000, 32'h0000_0000);
    rd(8'h80, 32'h0000_0032);
    // Block as slave 1, far side polls it, then goes silent
    wr(`MWL_A_CTRL, 32'h0000_0000);
    wr(`MWL_A_SRCLEN, 32'h0000_0001);
    wr(`MWL_A_STSET, 32'h0000_0001);
    wr(`MWL_A_CTRL, 32'h0000_0001);
    asMaster <= 1'b1;
    rd(`MWL_A_OWN, 32'h0000_0001);
    waitFlag(32'h0000_0001, 32'h0000_0000);
    repeat (80) @(posedge core_clk);
    chk(8'hF2, 32'h0000_0000, {28'h000_0000, lastTx[11:8]});
    asMaster <= 1'b0;
    waitFlag(32'h0000_0001, 32'h0000_0001);
    rd(8'h80, 32'h0000_0011);
    conclude;
  end
endmodule // mwl_link_tb_top
bind mwl_link mwl_link_props mwl_link_props_inst (
  .core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
  .pready(pready), .pslverr(pslverr), .txReq(txReq), .txDst(txDst),
  .txSeq(txSeq), .txStart(txStart), .txLen(txLen),
  .linkActive(linkActive), .cardMode(cardMode), .builtinMode(builtinMode));
